// *** hdl/idu_pkg.sv ***
// Constants and types shared by the integer divide unit
`default_nettype none
package idu_pkg;
  // Instruction decode
  localparam logic [5:0] PRIMARY_OP = 6'h1F;
  localparam logic [8:0] XO_DIV_SD = 9'h1E9;
  localparam logic [8:0] XO_DIV_UD = 9'h1C9;
  localparam logic [8:0] XO_DIV_SW = 9'h1EB;
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 26;
  localparam int XO_HI = 9;
  localparam int XO_LO = 1;
  localparam int OE_BIT = 10;
  localparam int COND_REC_BIT = 0;
  // Divider
  localparam logic [6:0] DIV_STEPS = 7'h40;
  localparam logic [63:0] DW_MIN = 64'h8000_0000_0000_0000;
  localparam logic [31:0] W_MIN = 32'h8000_0000;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_RES_LO = 8'h10;
  localparam logic [7:0] OFS_RES_HI = 8'h14;
  // Fields and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_RST = 1'b1;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_EXC_BIT = 1;
  localparam int IRQ_BAD_BIT = 2;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_FIN} idu_state_t;
endpackage
`default_nettype wire

// *** hdl/idu_divide_unit.sv ***
// Integer divide unit with AXI4-Lite status and interrupt registers
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module idu_divide_unit #(
  parameter int ADDR_W = 8
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic DIV_START,
  input wire logic [31:0] DIV_INSTR,
  input wire logic [63:0] FIRST_SOURCE_REG,
  input wire logic [63:0] SECOND_SOURCE_REG,
  input wire logic EXC_SO_IN,
  input wire logic MODE_64,
  output logic DIV_DONE,
  output logic DIV_BUSY,
  output logic DIV_BAD_OP,
  output logic [63:0] QUOTIENT,
  output logic [3:0] COND_FIELD_ZERO,
  output logic COND_FIELD_ZERO_WE,
  output logic EXC_SO,
  output logic ARITH_EXCESS_FLAG,
  output logic FIXED_POINT_EXC_REG_WE,
  output logic IRQ,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);

  function automatic logic [63:0] magn(input logic [63:0] x,
                                       input logic sgn);
    magn = (sgn && x[63]) ? 64'(-x) : x;
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    strb_merge = r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == idu_pkg::OFS_CTRL) || (a == idu_pkg::OFS_STATUS) ||
             (a == idu_pkg::OFS_IRQ_STAT) ||
             (a == idu_pkg::OFS_IRQ_MASK) ||
             (a == idu_pkg::OFS_RES_LO) || (a == idu_pkg::OFS_RES_HI);
  endfunction

  // Divider state
  idu_pkg::idu_state_t state, next_state;
  logic [6:0] cnt, next_cnt;
  logic [63:0] rem, next_rem;
  logic [63:0] dvd, next_dvd;
  logic [63:0] dsr, next_dsr;
  logic neg_q, next_neg_q;
  logic is_word, next_is_word;
  logic oe, next_oe;
  logic crec, next_crec;
  logic ovf, next_ovf;
  logic so_in, next_so_in;
  logic mode64, next_mode64;
  logic done, next_done;
  logic bad, next_bad;
  logic [63:0] quo, next_quo;
  logic [3:0] cr, next_cr;
  logic cr_we, next_cr_we;
  logic xso, next_xso;
  logic xov, next_xov;
  logic xwe, next_xwe;
  logic [8:0] xo;
  logic op_sd, op_ud, op_sw, op_ok;
  logic [63:0] a_ext, b_ext;
  logic [64:0] trial;
  logic [63:0] q_sgn;

  assign xo = DIV_INSTR[idu_pkg::XO_HI:idu_pkg::XO_LO];
  assign op_ok = (DIV_INSTR[idu_pkg::OPC_HI:idu_pkg::OPC_LO] ==
                  idu_pkg::PRIMARY_OP) && (op_sd || op_ud || op_sw);
  assign op_sd = (xo == idu_pkg::XO_DIV_SD);
  assign op_ud = (xo == idu_pkg::XO_DIV_UD);
  assign op_sw = (xo == idu_pkg::XO_DIV_SW);
  // Word form works on sign-extended low halves
  assign a_ext = op_sw ? {{32{FIRST_SOURCE_REG[31]}},
                          FIRST_SOURCE_REG[31:0]} : FIRST_SOURCE_REG;
  assign b_ext = op_sw ? {{32{SECOND_SOURCE_REG[31]}},
                          SECOND_SOURCE_REG[31:0]} : SECOND_SOURCE_REG;
  assign trial = {rem, dvd[63]};
  // Magnitudes divided, sign restored: truncation toward zero
  assign q_sgn = neg_q ? 64'(-dvd) : dvd;

  // Bus-side state
  logic enable, next_enable;
  logic [2:0] irq_stat, next_irq_stat;
  logic [2:0] irq_mask, next_irq_mask;
  logic irq, next_irq;
  logic aw_ok, next_aw_ok;
  logic w_ok, next_w_ok;
  logic [7:0] waddr, next_waddr;
  logic [31:0] wdata, next_wdata;
  logic [3:0] wstrb, next_wstrb;
  logic awready, next_awready;
  logic wready, next_wready;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic arready, next_arready;
  logic rvalid, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic [31:0] rd_mux;
  logic [2:0] events;
  logic [7:0] raddr;
  logic [31:0] mrg_ctrl, mrg_mask, mrg_clr;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_rem = rem;
    next_dvd = dvd;
    next_dsr = dsr;
    next_neg_q = neg_q;
    next_is_word = is_word;
    next_oe = oe;
    next_crec = crec;
    next_ovf = ovf;
    next_so_in = so_in;
    next_mode64 = mode64;
    next_done = 1'b0;
    next_bad = 1'b0;
    next_quo = quo;
    next_cr = cr;
    next_cr_we = 1'b0;
    next_xso = xso;
    next_xov = xov;
    next_xwe = 1'b0;
    unique case (state)
      idu_pkg::ST_IDLE: begin
        // Start is taken only when idle and enabled
        if (DIV_START && enable) begin
          if (!op_ok) begin
            next_done = 1'b1;
            next_bad = 1'b1;
          end else begin
            next_is_word = op_sw;
            next_oe = DIV_INSTR[idu_pkg::OE_BIT];
            next_crec = DIV_INSTR[idu_pkg::COND_REC_BIT];
            next_so_in = EXC_SO_IN;
            next_mode64 = MODE_64;
            next_neg_q = !op_ud && (a_ext[63] ^ b_ext[63]);
            next_dvd = magn(a_ext, !op_ud);
            next_dsr = magn(b_ext, !op_ud);
            next_rem = 64'h0;
            next_cnt = 7'h0;
            // Overflow cases skip the iteration entirely
            next_ovf = (b_ext == 64'h0) ||
                       (op_sd && a_ext == idu_pkg::DW_MIN &&
                        &b_ext) ||
                       (op_sw && a_ext[31:0] == idu_pkg::W_MIN &&
                        &b_ext);
            next_state = next_ovf ? idu_pkg::ST_FIN : idu_pkg::ST_RUN;
          end
        end
      end
      idu_pkg::ST_RUN: begin
        // One restoring step per clock
        if (trial >= {1'b0, dsr}) begin
          next_rem = 64'(trial - {1'b0, dsr});
          next_dvd = {dvd[62:0], 1'b1};
        end else begin
          next_rem = trial[63:0];
          next_dvd = {dvd[62:0], 1'b0};
        end
        next_cnt = 7'(cnt + 7'h1);
        if (cnt == 7'(idu_pkg::DIV_STEPS - 7'h1)) begin
          next_state = idu_pkg::ST_FIN;
        end
      end
      idu_pkg::ST_FIN: begin
        next_done = 1'b1;
        // Undefined results are driven as zero, so they stay repeatable
        next_quo = ovf ? 64'h0 : q_sgn;
        next_xso = so_in | (oe & ovf);
        next_xov = ovf;
        next_xwe = oe;
        next_cr_we = crec;
        if (ovf || (is_word && mode64)) begin
          next_cr = {3'h0, so_in | (oe & ovf)};
        end else if (is_word) begin
          next_cr = {q_sgn[31], !q_sgn[31] && |q_sgn[31:0],
                     ~|q_sgn[31:0], so_in};
        end else begin
          // Signed compare even for the unsigned form
          next_cr = {q_sgn[63], !q_sgn[63] && |q_sgn,
                     ~|q_sgn, so_in};
        end
        next_state = idu_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= idu_pkg::ST_IDLE;
      cnt <= 7'h0;
      rem <= 64'h0;
      dvd <= 64'h0;
      dsr <= 64'h0;
      neg_q <= 1'b0;
      is_word <= 1'b0;
      oe <= 1'b0;
      crec <= 1'b0;
      ovf <= 1'b0;
      so_in <= 1'b0;
      mode64 <= 1'b0;
      done <= 1'b0;
      bad <= 1'b0;
      quo <= 64'h0;
      cr <= 4'h0;
      cr_we <= 1'b0;
      xso <= 1'b0;
      xov <= 1'b0;
      xwe <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      rem <= next_rem;
      dvd <= next_dvd;
      dsr <= next_dsr;
      neg_q <= next_neg_q;
      is_word <= next_is_word;
      oe <= next_oe;
      crec <= next_crec;
      ovf <= next_ovf;
      so_in <= next_so_in;
      mode64 <= next_mode64;
      done <= next_done;
      bad <= next_bad;
      quo <= next_quo;
      cr <= next_cr;
      cr_we <= next_cr_we;
      xso <= next_xso;
      xov <= next_xov;
      xwe <= next_xwe;
    end
  end

  assign events = {next_bad, next_done && next_ovf && !next_bad,
                   next_done};
  assign raddr = 8'(ARADDR);
  // Strobe merges named apart, a call result cannot be bit-selected
  assign mrg_ctrl = strb_merge({31'h0, enable}, wdata, wstrb);
  assign mrg_mask = strb_merge({29'h0, irq_mask}, wdata, wstrb);
  assign mrg_clr = strb_merge(32'h0, wdata, wstrb);

  always_comb begin
    rd_mux = 32'h0;
    unique case (raddr)
      idu_pkg::OFS_CTRL: rd_mux = {31'h0, enable};
      idu_pkg::OFS_STATUS: rd_mux = {24'h0, cr, 2'h0, xov,
                                     state != idu_pkg::ST_IDLE};
      idu_pkg::OFS_IRQ_STAT: rd_mux = {29'h0, irq_stat};
      idu_pkg::OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask};
      idu_pkg::OFS_RES_LO: rd_mux = quo[31:0];
      idu_pkg::OFS_RES_HI: rd_mux = quo[63:32];
      default: rd_mux = 32'h0;
    endcase
  end

  always_comb begin
    next_enable = enable;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_aw_ok = aw_ok;
    next_w_ok = w_ok;
    next_waddr = waddr;
    next_wdata = wdata;
    next_wstrb = wstrb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_arready = arready;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (AWVALID && awready) begin
      next_aw_ok = 1'b1;
      next_waddr = 8'(AWADDR);
    end
    if (WVALID && wready) begin
      next_w_ok = 1'b1;
      next_wdata = WDATA;
      next_wstrb = WSTRB;
    end
    if (BVALID && BREADY) begin
      next_bvalid = 1'b0;
    end
    if (aw_ok && w_ok && !bvalid) begin
      next_aw_ok = 1'b0;
      next_w_ok = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(waddr) ? idu_pkg::RESP_OKAY :
                   idu_pkg::RESP_SLVERR;
      if (waddr == idu_pkg::OFS_CTRL) begin
        next_enable = mrg_ctrl[idu_pkg::CTRL_EN_BIT];
      end
      if (waddr == idu_pkg::OFS_IRQ_MASK) begin
        next_irq_mask = mrg_mask[2:0];
      end
      if (waddr == idu_pkg::OFS_IRQ_STAT) begin
        next_irq_stat = irq_stat & ~mrg_clr[2:0];
      end
    end
    // A new event wins over a clear in the same cycle
    next_irq_stat = next_irq_stat | events;
    next_awready = !next_aw_ok;
    next_wready = !next_w_ok;
    if (ARVALID && arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = rd_mux;
      next_rresp = mapped(raddr) ? idu_pkg::RESP_OKAY :
                   idu_pkg::RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      enable <= idu_pkg::CTRL_RST;
      irq_mask <= idu_pkg::IRQ_MASK_RST;
      irq_stat <= 3'h0;
      irq <= 1'b0;
      aw_ok <= 1'b0;
      w_ok <= 1'b0;
      waddr <= 8'h0;
      wdata <= 32'h0;
      wstrb <= 4'h0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rresp <= 2'h0;
      rdata <= 32'h0;
    end else begin
      enable <= next_enable;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
      irq <= next_irq;
      aw_ok <= next_aw_ok;
      w_ok <= next_w_ok;
      waddr <= next_waddr;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DIV_BUSY <= 1'b0;
    end else begin
      DIV_BUSY <= next_state != idu_pkg::ST_IDLE;
    end
  end

  assign DIV_DONE = done;
  assign DIV_BAD_OP = bad;
  assign QUOTIENT = quo;
  assign COND_FIELD_ZERO = cr;
  assign COND_FIELD_ZERO_WE = cr_we;
  assign EXC_SO = xso;
  assign ARITH_EXCESS_FLAG = xov;
  assign FIXED_POINT_EXC_REG_WE = xwe;
  assign IRQ = irq;
  assign AWREADY = awready;
  assign WREADY = wready;
  assign BRESP = bresp;
  assign BVALID = bvalid;
  assign ARREADY = arready;
  assign RDATA = rdata;
  assign RRESP = rresp;
  assign RVALID = rvalid;

endmodule
`default_nettype wire

// *** dv/idu_divide_props.sv ***
// Concurrent checks on the divide unit ports
`timescale 1ns/100ps
`default_nettype none
module idu_divide_props (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic DIV_START,
  input wire logic DIV_DONE,
  input wire logic DIV_BUSY,
  input wire logic DIV_BAD_OP,
  input wire logic [63:0] QUOTIENT,
  input wire logic [3:0] COND_FIELD_ZERO,
  input wire logic COND_FIELD_ZERO_WE,
  input wire logic EXC_SO,
  input wire logic ARITH_EXCESS_FLAG,
  input wire logic FIXED_POINT_EXC_REG_WE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  chk_done_pulse: assert property (DIV_DONE |=> !DIV_DONE)
    else $error("done pulse too long");
  chk_busy_cause: assert property ($rose(DIV_BUSY) |-> $past(DIV_START))
    else $error("busy without start");
  chk_done_bound: assert property ($rose(DIV_BUSY) |-> ##[0:65] DIV_DONE)
    else $error("divide too slow");
  chk_cr_we_done: assert property (COND_FIELD_ZERO_WE |-> DIV_DONE)
    else $error("condition write outside done");
  chk_exc_we_done: assert property (FIXED_POINT_EXC_REG_WE |-> DIV_DONE)
    else $error("exception write outside done");
  chk_bad_done: assert property (DIV_BAD_OP |-> DIV_DONE)
    else $error("bad op without done");
  chk_ov_quot: assert property (FIXED_POINT_EXC_REG_WE && ARITH_EXCESS_FLAG |-> QUOTIENT == 64'h0)
    else $error("overflow quotient not cleared");
  chk_sticky_set: assert property (FIXED_POINT_EXC_REG_WE && ARITH_EXCESS_FLAG |-> EXC_SO)
    else $error("sticky excess not set");
  chk_cr_sign: assert property (COND_FIELD_ZERO_WE |-> $onehot0(COND_FIELD_ZERO[3:1]) && (!COND_FIELD_ZERO[1] || QUOTIENT == 64'h0) && (!COND_FIELD_ZERO[3] || QUOTIENT[63]))
    else $error("condition bits disagree with quotient");
  chk_quot_hold: assert property (!DIV_DONE |-> $stable(QUOTIENT))
    else $error("quotient moved without done");
  cover property (FIXED_POINT_EXC_REG_WE && ARITH_EXCESS_FLAG);
  cover property (DIV_BAD_OP);
  cover property (COND_FIELD_ZERO_WE && COND_FIELD_ZERO[3]);
endmodule
`default_nettype wire

// *** dv/idu_issue_model.sv ***
// Issue and writeback side model driving the divide port
`timescale 1ns/100ps
`default_nettype none
module idu_issue_model (
  input wire logic clk,
  input wire logic done,
  output logic start,
  output logic [31:0] instr,
  output logic [63:0] src_a,
  output logic [63:0] src_b,
  output logic so,
  output logic mode64
);
  initial begin
    start = 1'b0;
    instr = 32'h0;
    src_a = 64'h0;
    src_b = 64'h0;
    so = 1'b0;
    mode64 = 1'b0;
  end
  // Operands scrambled after take, so late sampling shows up
  task automatic issue(input logic [31:0] i, input logic [63:0] a, b,
    input logic s, m, output int lat);
    @(posedge clk);
    start <= 1'b1;
    instr <= i;
    src_a <= a;
    src_b <= b;
    so <= s;
    mode64 <= m;
    @(posedge clk);
    start <= 1'b0;
    instr <= ~i;
    src_a <= ~a;
    src_b <= ~b;
    #1;
    lat = 0;
    while (done !== 1'b1 && lat < 100) begin
      @(posedge clk);
      #1;
      lat++;
    end
  endtask
endmodule
`default_nettype wire

// *** dv/tb_integer_divide_unit.sv ***
// Self-checking bench for the integer divide unit
`timescale 1ns/100ps
`default_nettype none
`define CK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED at %0t: value mismatch", $time); end end
module tb_integer_divide_unit;
  logic CORE_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic DIV_START, EXC_SO_IN, MODE_64, DIV_DONE, DIV_BUSY, DIV_BAD_OP, IRQ;
  logic [31:0] DIV_INSTR, WDATA, RDATA, d;
  logic [63:0] FIRST_SOURCE_REG, SECOND_SOURCE_REG, QUOTIENT, lastq, a, b;
  logic [3:0] COND_FIELD_ZERO;
  logic COND_FIELD_ZERO_WE, EXC_SO, ARITH_EXCESS_FLAG, FIXED_POINT_EXC_REG_WE;
  logic [7:0] AWADDR, ARADDR;
  logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic ARVALID, ARREADY, RVALID, RREADY;
  logic [1:0] BRESP, RRESP, r;
  logic [31:0] seed = 32'hE10750D3;
  logic [31:0] ins;
  logic [31:0] base [3] = '{32'h7C00_03D2, 32'h7C00_0392, 32'h7C00_03D6};
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int lat;
  always #5 CORE_CLK = ~CORE_CLK;
  idu_divide_unit idu_divide_unit_i (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
    .DIV_START(DIV_START), .DIV_INSTR(DIV_INSTR), .EXC_SO_IN(EXC_SO_IN),
    .FIRST_SOURCE_REG(FIRST_SOURCE_REG), .SECOND_SOURCE_REG(SECOND_SOURCE_REG),
    .MODE_64(MODE_64), .DIV_DONE(DIV_DONE), .DIV_BUSY(DIV_BUSY),
    .DIV_BAD_OP(DIV_BAD_OP), .QUOTIENT(QUOTIENT), .IRQ(IRQ),
    .COND_FIELD_ZERO(COND_FIELD_ZERO), .COND_FIELD_ZERO_WE(COND_FIELD_ZERO_WE),
    .EXC_SO(EXC_SO), .ARITH_EXCESS_FLAG(ARITH_EXCESS_FLAG),
    .FIXED_POINT_EXC_REG_WE(FIXED_POINT_EXC_REG_WE), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hF),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
  idu_issue_model idu_issue_model_i (.clk(CORE_CLK), .done(DIV_DONE),
    .start(DIV_START), .instr(DIV_INSTR), .src_a(FIRST_SOURCE_REG),
    .src_b(SECOND_SOURCE_REG), .so(EXC_SO_IN), .mode64(MODE_64));
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic void model(input logic [31:0] ins, input logic [63:0] a,
    b, input logic so, m, output logic [63:0] q, output logic [3:0] cr,
    output logic exc, output logic bad);
    logic [8:0] xo;
    logic [31:0] w;
    xo = ins[9:1];
    bad = ins[31:26] != 6'h1F || !(xo inside {9'h1E9, 9'h1C9, 9'h1EB});
    q = 64'h0;
    w = 32'h0;
    if (xo == 9'h1E9) begin
      exc = b == 64'h0 || (a == 64'h8000_0000_0000_0000 && &b);
      if (!exc) q = $signed(a) / $signed(b);
    end else if (xo == 9'h1C9) begin
      exc = b == 64'h0;
      if (!exc) q = a / b;
    end else begin
      exc = b[31:0] == 32'h0 || (a[31:0] == 32'h8000_0000 && &b[31:0]);
      // Not in a conditional: an unsigned arm would make it unsigned
      if (!exc) w = $signed(a[31:0]) / $signed(b[31:0]);
      q = {{32{w[31]}}, w};
    end
    cr = {q[63], !q[63] && q != 64'h0, q == 64'h0, so | (ins[10] & exc)};
    if (exc || (xo == 9'h1EB && m)) cr[3:1] = 3'h0;
  endfunction
  task automatic axw(input logic [7:0] ad, input logic [31:0] dt,
    output logic [1:0] rs);
    @(posedge CORE_CLK);
    AWADDR <= ad;
    WDATA <= dt;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (BVALID !== 1'b1);
    rs = BRESP;
    BREADY <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] ad, output logic [31:0] dt,
    output logic [1:0] rs);
    @(posedge CORE_CLK);
    ARADDR <= ad;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1);
    dt = RDATA;
    rs = RRESP;
    RREADY <= 1'b0;
  endtask
  task automatic wt();
    repeat (3) @(posedge CORE_CLK);
    #1;
  endtask
  task automatic run(input logic [31:0] ins, input logic [63:0] a, b);
    logic [63:0] q;
    logic [3:0] cr;
    logic exc, bad, so, m;
    int lc;
    so = seed[3];
    m = seed[4];
    model(ins, a, b, so, m, q, cr, exc, bad);
    idu_issue_model_i.issue(ins, a, b, so, m, lc);
    // Edges after the take edge: one per step plus the finish cycle
    `CK(lc, bad ? 0 : exc ? 1 : int'(idu_pkg::DIV_STEPS) + 1)
    `CK(DIV_BAD_OP, bad)
    if (!bad) begin
      lastq = q;
      `CK(QUOTIENT, q)
      `CK(COND_FIELD_ZERO_WE, ins[0])
      if (ins[0]) `CK(COND_FIELD_ZERO, cr)
      `CK(FIXED_POINT_EXC_REG_WE, ins[10])
      if (ins[10]) `CK(ARITH_EXCESS_FLAG, exc)
      if (ins[10]) `CK(EXC_SO, so | exc)
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    {AWADDR, ARADDR, WDATA} = 48'h0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h0;
    repeat (3) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    axr(idu_pkg::OFS_CTRL, d, r);
    `CK(d, 32'h0000_0001)
    axr(idu_pkg::OFS_IRQ_MASK, d, r);
    `CK(d, 32'h0000_0000)
    axr(8'h20, d, r);
    `CK(r, idu_pkg::RESP_SLVERR)
    axw(idu_pkg::OFS_IRQ_MASK, 32'h0000_0007, r);
    `CK(r, idu_pkg::RESP_OKAY)
    // Last twelve: minimum by minus one, and zero divisors
    for (int i = 0; i < 48; i++) begin
      ins = base[i % 3] | {21'h0, (i / 3) % 4 > 1, 9'h0, (i / 3) % 2 == 1};
      a = {rnd(), rnd()};
      b = {rnd(), rnd()} >> seed[5:0];
      if (i >= 36) b = (i % 2) ? 64'h0 : '1;
      if (i >= 36 && i % 2 == 0)
        a = (i % 3 == 2) ? 64'h8000_0000 : 64'h8000_0000_0000_0000;
      run(ins, a, b);
    end
    wt();
    `CK(IRQ, 1'b1)
    axr(idu_pkg::OFS_RES_LO, d, r);
    `CK(d, lastq[31:0])
    axw(idu_pkg::OFS_IRQ_STAT, 32'h0000_0007, r);
    wt();
    `CK(IRQ, 1'b0)
    run(32'h7C00_03D4, 64'h9, 64'h3);
    run(32'h7800_03D2, 64'h9, 64'h3);
    wt();
    `CK(IRQ, 1'b1)
    axw(idu_pkg::OFS_CTRL, 32'h0000_0000, r);
    idu_issue_model_i.issue(32'h7C00_03D2, 64'h8, 64'h2, 1'b0, 1'b0, lat);
    `CK(lat, 100)
    axw(idu_pkg::OFS_CTRL, 32'h0000_0001, r);
    run(32'h7C00_0393, 64'h8, 64'h2);
    report_and_stop();
  end
endmodule
bind idu_divide_unit idu_divide_props idu_divide_props_i (
  .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .DIV_START(DIV_START),
  .DIV_DONE(DIV_DONE), .DIV_BUSY(DIV_BUSY), .DIV_BAD_OP(DIV_BAD_OP),
  .QUOTIENT(QUOTIENT), .COND_FIELD_ZERO(COND_FIELD_ZERO),
  .COND_FIELD_ZERO_WE(COND_FIELD_ZERO_WE), .EXC_SO(EXC_SO),
  .ARITH_EXCESS_FLAG(ARITH_EXCESS_FLAG),
  .FIXED_POINT_EXC_REG_WE(FIXED_POINT_EXC_REG_WE));
`default_nettype wire
